// ===== hw/fbar_pkg.sv
// Constants, types and helpers shared by the fieldbus alarm reset control block.
// How it works
// - Control word two of 256 asks for reset; device clears its pending alarm.
// - Pending failure alarm with start withdrawn reports 5128 in status word two.
// - That state shows sonics-off and equipment-failure bits both set.
// - Reset clearing the alarm makes status word two read 1024, ready.
// - After reset is released with zero, status word two keeps reading 1024.
// - Control word two of zero means no command; device stays ready.
// - Device sends a 20-byte status image every channel cycle.
// - Device takes an 8-byte control image as its control information.
// - Automatic mode sets status word one bits 4 and 14, value 16400.
// - Control word one bit 14, value 16384, requests automatic mode.
// - Control word two bit 0 is function enable, bit 8 is on.
// - Cycle completion sets end-of-cycle bit 12 and sonics-off bit 10.
// - Start still held after the cycle raises an alarm with equipment failure, 4104.
package fbar_pkg;

  // ----------------------------------------------------------------
  // Image sizes and word positions
  // ----------------------------------------------------------------
  localparam int CTL_IMAGE_BYTES = 8;
  localparam int STAT_IMAGE_BYTES = 20;
  localparam int CTL_CW1_WORD = 0;
  localparam int CTL_CW2_WORD = 1;
  localparam logic [3:0] STAT_SW1_WORD = 4'h2;
  localparam logic [3:0] STAT_SW2_WORD = 4'h3;

  // ----------------------------------------------------------------
  // Control and status word bits and codes
  // ----------------------------------------------------------------
  localparam int CW1_AUTO_BIT = 14;
  localparam int CW2_FUNC_BIT = 0;
  localparam int CW2_ON_BIT = 8;
  localparam logic [15:0] SW1_AUTO = 16'h4010;
  localparam logic [15:0] SW1_MANUAL = 16'h0000;
  localparam logic [15:0] SW2_READY = 16'h0400;
  localparam logic [15:0] SW2_WELD = 16'h0800;
  localparam logic [15:0] SW2_HOLD = 16'h0000;
  localparam logic [15:0] SW2_DONE = 16'h1400;
  localparam logic [15:0] SW2_FAIL_HELD = 16'h1008;
  localparam logic [15:0] SW2_FAIL_OFF = 16'h1408;

  // ----------------------------------------------------------------
  // Register map and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_STATUS_WORDS = 8'h08;
  localparam logic [7:0] REG_CONTROL_WORDS = 8'h0C;
  localparam logic [7:0] REG_HOLD_LIMIT = 8'h10;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_RESET = 2;
  localparam int IRQ_IMAGE = 3;
  localparam int IRQ_BITS = 4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int START_HOLD_TIME_MS = 1;
  localparam int START_HOLD_CYCLES = START_HOLD_TIME_MS * (CLK_FREQ_HZ / 1000);

  typedef enum logic [2:0] {
    ST_READY,
    ST_WELD,
    ST_HOLD,
    ST_DONE,
    ST_ALARM
  } fbar_state_t;

  // Start request is the function enable bit; the on bit alone asks for a reset.
  function automatic logic start_req(input logic [15:0] cw2);
    return cw2[CW2_FUNC_BIT];
  endfunction

  // Reset request is on without function enable.
  function automatic logic reset_req(input logic [15:0] cw2);
    return cw2[CW2_ON_BIT] & ~cw2[CW2_FUNC_BIT];
  endfunction

endpackage

// ===== hw/fbar_ctl_rx.sv
// Assembles the control image bytes into the two control words.
`timescale 1ns/10ps
module fbar_ctl_rx #(
  parameter int BYTES = fbar_pkg::CTL_IMAGE_BYTES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] byte_i,
  input wire logic valid_i,
  input wire logic first_i,
  output logic [15:0] cw1_o,
  output logic [15:0] cw2_o,
  output logic update_o
);

  localparam int IW = $clog2(BYTES + 1);
  localparam logic [IW-1:0] LAST = IW'(BYTES - 1);

  typedef struct packed {
    logic [IW-1:0] idx;
    logic [BYTES*8-1:0] image;
    logic [15:0] cw1;
    logic [15:0] cw2;
    logic upd;
  } fbar_rx_t;

  fbar_rx_t s_reg;
  fbar_rx_t s_next;

  // ----------------------------------------------------------------
  // Byte collection
  // ----------------------------------------------------------------
  always_comb begin
    logic [IW-1:0] pos;
    logic [BYTES*8-1:0] img;
    pos = first_i ? '0 : s_reg.idx;
    img = s_reg.image;
    s_next = s_reg;
    s_next.upd = 1'b0;
    if (valid_i && (first_i || s_reg.idx < IW'(BYTES))) begin
      img[pos*8 +: 8] = byte_i;
      s_next.image = img;
      s_next.idx = pos + 1'b1;
      if (pos == LAST) begin
        s_next.cw1 = img[fbar_pkg::CTL_CW1_WORD*16 +: 16];
        s_next.cw2 = img[fbar_pkg::CTL_CW2_WORD*16 +: 16];
        s_next.upd = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{idx: IW'(BYTES), image: '0, cw1: 16'h0000, cw2: 16'h0000, upd: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign cw1_o = s_reg.cw1;
  assign cw2_o = s_reg.cw2;
  assign update_o = s_reg.upd;

endmodule

// ===== hw/fbar_ctrl.sv
// Control and status word handling with the alarm reset handshake.
`timescale 1ns/10ps
module fbar_ctrl #(
  parameter int START_HOLD_CYCLES = fbar_pkg::START_HOLD_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] ctl_byte_i,
  input wire logic ctl_valid_i,
  input wire logic ctl_first_i,
  input wire logic cycle_tick_i,
  input wire logic weld_done_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic [7:0] stat_byte_o,
  output logic stat_valid_o,
  output logic stat_first_o,
  output logic [15:0] status_word_one_o,
  output logic [15:0] status_word_two_o,
  output logic sonics_on_o,
  output logic alarm_o,
  output logic irq_o
);

  localparam int NB = fbar_pkg::STAT_IMAGE_BYTES;
  localparam logic [4:0] LAST_BYTE = 5'(NB - 1);
  localparam logic [31:0] HOLD_RESET = 32'(START_HOLD_CYCLES);

  typedef struct packed {
    fbar_pkg::fbar_state_t state;
    logic [31:0] hold_cnt;
    logic [31:0] hold_lim;
    logic [15:0] sw1;
    logic [15:0] sw2;
    logic [fbar_pkg::IRQ_BITS-1:0] irq_stat;
    logic [fbar_pkg::IRQ_BITS-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
    logic [15:0] tx_sw1;
    logic [15:0] tx_sw2;
    logic [4:0] tx_idx;
    logic tx_busy;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_first;
    logic sonics;
    logic alarm;
  } fbar_ctrl_t;

  fbar_ctrl_t s_reg;
  fbar_ctrl_t s_next;

  logic [15:0] cw1;
  logic [15:0] cw2;
  logic img_upd;

  // ----------------------------------------------------------------
  // Control image receiver
  // ----------------------------------------------------------------
  fbar_ctl_rx #(
    .BYTES(fbar_pkg::CTL_IMAGE_BYTES)
  ) u_rx (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .byte_i(ctl_byte_i),
    .valid_i(ctl_valid_i),
    .first_i(ctl_first_i),
    .cw1_o(cw1),
    .cw2_o(cw2),
    .update_o(img_upd)
  );

  // Picks one byte of a status word, low byte first.
  function automatic logic [7:0] word_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic start;
    logic rst_req;
    logic auto;
    logic [fbar_pkg::IRQ_BITS-1:0] ev;
    logic [fbar_pkg::IRQ_BITS-1:0] clr;
    logic [3:0] word;
    start = fbar_pkg::start_req(cw2);
    rst_req = fbar_pkg::reset_req(cw2);
    auto = cw1[fbar_pkg::CW1_AUTO_BIT];
    ev = '0;
    clr = '0;
    word = 4'h0;
    s_next = s_reg;

    // ------------------------------------------------------------
    // Weld cycle and alarm handshake
    // ------------------------------------------------------------
    case (s_reg.state)
      fbar_pkg::ST_READY: begin
        // A zero control word two is no command and leaves the unit ready.
        if (start && auto) begin
          s_next.state = fbar_pkg::ST_WELD;
        end
      end
      fbar_pkg::ST_WELD: begin
        if (weld_done_i) begin
          s_next.state = fbar_pkg::ST_HOLD;
          s_next.hold_cnt = 32'h0000_0000;
        end
      end
      fbar_pkg::ST_HOLD: begin
        if (!start) begin
          s_next.state = fbar_pkg::ST_DONE;
          ev[fbar_pkg::IRQ_DONE] = 1'b1;
        end else if (s_reg.hold_cnt + 32'h0000_0001 >= s_reg.hold_lim) begin
          s_next.state = fbar_pkg::ST_ALARM;
          ev[fbar_pkg::IRQ_ALARM] = 1'b1;
        end else begin
          s_next.hold_cnt = s_reg.hold_cnt + 32'h0000_0001;
        end
      end
      fbar_pkg::ST_DONE: begin
        if (start && auto) begin
          s_next.state = fbar_pkg::ST_WELD;
        end
      end
      fbar_pkg::ST_ALARM: begin
        // Only a reset with function enable clear clears the alarm.
        if (rst_req) begin
          s_next.state = fbar_pkg::ST_READY;
          ev[fbar_pkg::IRQ_RESET] = 1'b1;
        end
      end
      default: begin
        s_next.state = fbar_pkg::ST_READY;
      end
    endcase

    // ------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------
    s_next.sw1 = auto ? fbar_pkg::SW1_AUTO : fbar_pkg::SW1_MANUAL;
    case (s_next.state)
      fbar_pkg::ST_READY: s_next.sw2 = fbar_pkg::SW2_READY;
      fbar_pkg::ST_WELD: s_next.sw2 = fbar_pkg::SW2_WELD;
      fbar_pkg::ST_HOLD: s_next.sw2 = fbar_pkg::SW2_HOLD;
      fbar_pkg::ST_DONE: s_next.sw2 = fbar_pkg::SW2_DONE;
      fbar_pkg::ST_ALARM: begin
        if (start) begin
          s_next.sw2 = fbar_pkg::SW2_FAIL_HELD;
        end else begin
          s_next.sw2 = fbar_pkg::SW2_FAIL_OFF;
        end
      end
      default: s_next.sw2 = fbar_pkg::SW2_READY;
    endcase
    s_next.sonics = (s_next.state == fbar_pkg::ST_WELD);
    s_next.alarm = (s_next.state == fbar_pkg::ST_ALARM);
    ev[fbar_pkg::IRQ_IMAGE] = img_upd;

    // ------------------------------------------------------------
    // Status image sender
    // ------------------------------------------------------------
    s_next.tx_valid = 1'b0;
    s_next.tx_first = 1'b0;
    if (s_reg.tx_busy) begin
      word = 4'(s_reg.tx_idx >> 1);
      if (word == fbar_pkg::STAT_SW1_WORD) begin
        s_next.tx_byte = word_byte(s_reg.tx_sw1, s_reg.tx_idx[0]);
      end else if (word == fbar_pkg::STAT_SW2_WORD) begin
        s_next.tx_byte = word_byte(s_reg.tx_sw2, s_reg.tx_idx[0]);
      end else begin
        s_next.tx_byte = 8'h00;
      end
      s_next.tx_valid = 1'b1;
      s_next.tx_first = (s_reg.tx_idx == 5'h00);
      s_next.tx_idx = s_reg.tx_idx + 5'h01;
      if (s_reg.tx_idx == LAST_BYTE) begin
        s_next.tx_busy = 1'b0;
      end
    end else if (cycle_tick_i) begin
      s_next.tx_busy = 1'b1;
      s_next.tx_idx = 5'h00;
      s_next.tx_sw1 = s_reg.sw1;
      s_next.tx_sw2 = s_reg.sw2;
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    s_next.rdata = 32'h0000_0000;
    if (wr_i) begin
      if (addr_i == fbar_pkg::REG_IRQ_STATUS) begin
        clr = wdata_i[fbar_pkg::IRQ_BITS-1:0];
      end else if (addr_i == fbar_pkg::REG_IRQ_MASK) begin
        s_next.irq_mask = wdata_i[fbar_pkg::IRQ_BITS-1:0];
      end else if (addr_i == fbar_pkg::REG_HOLD_LIMIT) begin
        s_next.hold_lim = (wdata_i == 32'h0000_0000) ? 32'h0000_0001 : wdata_i;
      end
    end
    if (rd_i) begin
      if (addr_i == fbar_pkg::REG_IRQ_STATUS) begin
        s_next.rdata = 32'(s_reg.irq_stat);
      end else if (addr_i == fbar_pkg::REG_IRQ_MASK) begin
        s_next.rdata = 32'(s_reg.irq_mask);
      end else if (addr_i == fbar_pkg::REG_STATUS_WORDS) begin
        s_next.rdata = {s_reg.sw2, s_reg.sw1};
      end else if (addr_i == fbar_pkg::REG_CONTROL_WORDS) begin
        s_next.rdata = {cw2, cw1};
      end else if (addr_i == fbar_pkg::REG_HOLD_LIMIT) begin
        s_next.rdata = s_reg.hold_lim;
      end
    end

    // A new event wins over a clear written in the same cycle.
    s_next.irq_stat = (s_reg.irq_stat & ~clr) | ev;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{
        state: fbar_pkg::ST_READY,
        hold_cnt: 32'h0000_0000,
        hold_lim: HOLD_RESET,
        sw1: fbar_pkg::SW1_MANUAL,
        sw2: fbar_pkg::SW2_READY,
        irq_stat: '0,
        irq_mask: '0,
        irq: 1'b0,
        rdata: 32'h0000_0000,
        tx_sw1: 16'h0000,
        tx_sw2: 16'h0000,
        tx_idx: 5'h00,
        tx_busy: 1'b0,
        tx_byte: 8'h00,
        tx_valid: 1'b0,
        tx_first: 1'b0,
        sonics: 1'b0,
        alarm: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata_o = s_reg.rdata;
  assign stat_byte_o = s_reg.tx_byte;
  assign stat_valid_o = s_reg.tx_valid;
  assign stat_first_o = s_reg.tx_first;
  assign status_word_one_o = s_reg.sw1;
  assign status_word_two_o = s_reg.sw2;
  assign sonics_on_o = s_reg.sonics;
  assign alarm_o = s_reg.alarm;
  assign irq_o = s_reg.irq;

endmodule

// ===== tb/fbar_ctrl_properties.sv
// Concurrent checks on the ports of the alarm reset control block.
`timescale 1ns/10ps
module fbar_ctrl_properties #(
  parameter int START_HOLD_CYCLES = 8
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic cycle_tick_i,
  input wire logic ctl_valid_i,
  input wire logic stat_valid_o,
  input wire logic stat_first_o,
  input wire logic [15:0] status_word_one_o,
  input wire logic [15:0] status_word_two_o,
  input wire logic sonics_on_o,
  input wire logic alarm_o
);
  // ----------------------------------------------------------------
  // Port relations
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  a_sw1_codes: assert property (status_word_one_o inside {16'h4010, 16'h0000})
    else $error("bad status word one");
  a_image_len: assert property (stat_first_o |-> stat_valid_o [*8] ##1 stat_valid_o [*8]
    ##1 stat_valid_o [*4] ##1 (!stat_valid_o || stat_first_o)) else $error("bad image length");
  a_image_start: assert property (stat_first_o |-> $past(cycle_tick_i, 2))
    else $error("image without tick");
  a_fail_codes: assert property (alarm_o |-> status_word_two_o inside {16'h1008, 16'h1408})
    else $error("bad alarm code");
  a_alarm_clear: assert property ($fell(alarm_o) |-> status_word_two_o == 16'h0400)
    else $error("alarm cleared but not ready");
  a_fail_hold: assert property (status_word_two_o == 16'h1408 && !ctl_valid_i
    && !$past(ctl_valid_i) && !$past(ctl_valid_i, 2) |=> status_word_two_o == 16'h1408)
    else $error("failure code lost");
  a_sonics_weld: assert property (sonics_on_o |-> status_word_two_o == 16'h0800
    && status_word_one_o == 16'h4010) else $error("weld without auto");
  a_done_code: assert property (status_word_two_o[12]
    |-> status_word_two_o inside {16'h1400, 16'h1008, 16'h1408}) else $error("bad end code");
  cover property ($rose(alarm_o));
  cover property ($fell(alarm_o));
  cover property (stat_first_o);
endmodule

bind fbar_ctrl fbar_ctrl_properties #(.START_HOLD_CYCLES(START_HOLD_CYCLES)) fbar_chk_inst (
  .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cycle_tick_i(cycle_tick_i),
  .ctl_valid_i(ctl_valid_i), .stat_valid_o(stat_valid_o), .stat_first_o(stat_first_o),
  .status_word_one_o(status_word_one_o), .status_word_two_o(status_word_two_o),
  .sonics_on_o(sonics_on_o), .alarm_o(alarm_o));

// ===== tb/fbar_plc_model.sv
// Controller model: sends control images and collects status images.
`timescale 1ns/10ps
module fbar_plc_model (
  input wire logic core_clk_i,
  input wire logic go_i,
  input wire logic [15:0] cw1_i,
  input wire logic [15:0] cw2_i,
  input wire logic [7:0] fill_i,
  input wire logic [7:0] stat_byte_i,
  input wire logic stat_valid_i,
  input wire logic stat_first_i,
  output logic [7:0] ctl_byte_o,
  output logic ctl_valid_o,
  output logic ctl_first_o,
  output logic [159:0] rx_o,
  output int rx_cnt_o
);
  // ----------------------------------------------------------------
  // Control image out, status image in
  // ----------------------------------------------------------------
  logic [63:0] img = '0;
  int idx = 8;
  assign ctl_valid_o = idx < 8;
  assign ctl_first_o = idx == 0;
  assign ctl_byte_o = ctl_valid_o ? img[idx*8 +: 8] : ~img[63:56];
  always @(posedge core_clk_i) begin
    if (go_i) begin
      img <= {{4{fill_i}}, cw2_i, cw1_i};
      idx <= 0;
    end else if (idx < 8) begin
      idx <= idx + 1;
    end
    if (stat_valid_i) begin
      rx_o <= {stat_byte_i, rx_o[159:8]};
      rx_cnt_o <= stat_first_i ? 1 : rx_cnt_o + 1;
    end
  end
endmodule

// ===== tb/fbar_ctrl_bench.sv
// Self-checking bench for the alarm reset control block.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t got %0h expected %0h", $time, (a), (b)); end end
module fbar_ctrl_bench;
  logic core_clk_i, arst_n_i, go, tick, wdone, wr, rd, sonics, alarm, irq, sv, sf, cv, cf;
  logic [7:0] addr, sb, cb, fill;
  logic [15:0] cw1, cw2, sw1, sw2;
  logic [31:0] wdata, rdata;
  logic [159:0] rx;
  int rx_cnt, errors = 0, n_checks = 0, seed = 8, ms = 0;
  bit held = 0, auto = 0;
  fbar_ctrl #(.START_HOLD_CYCLES(8)) fbar_ctrl_inst (.core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i), .ctl_byte_i(cb), .ctl_valid_i(cv), .ctl_first_i(cf),
    .cycle_tick_i(tick), .weld_done_i(wdone), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .stat_byte_o(sb), .stat_valid_o(sv), .stat_first_o(sf),
    .status_word_one_o(sw1), .status_word_two_o(sw2), .sonics_on_o(sonics),
    .alarm_o(alarm), .irq_o(irq));
  fbar_plc_model fbar_plc_model_inst (.core_clk_i(core_clk_i), .go_i(go), .cw1_i(cw1),
    .cw2_i(cw2), .fill_i(fill), .stat_byte_i(sb), .stat_valid_i(sv), .stat_first_i(sf),
    .ctl_byte_o(cb), .ctl_valid_o(cv), .ctl_first_o(cf), .rx_o(rx), .rx_cnt_o(rx_cnt));
  // ----------------------------------------------------------------
  // Reference model and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] esw1();
    return auto ? 16'h4010 : 16'h0000;
  endfunction
  function automatic logic [15:0] esw2();
    case (ms)
      0: return 16'h0400;
      1: return 16'h0800;
      2: return 16'h0000;
      3: return 16'h1400;
      default: return held ? 16'h1008 : 16'h1408;
    endcase
  endfunction
  task automatic check_state();
    #1;
    `CHK(sw1, esw1())
    `CHK(sw2, esw2())
    `CHK(sonics, ms == 1)
    `CHK(alarm, ms == 4)
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic send(input logic [15:0] c1, input logic [15:0] c2);
    bit st, rs;
    @(posedge core_clk_i);
    cw1 <= c1;
    cw2 <= c2;
    fill <= 8'($random(seed));
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    st = c2[0];
    rs = c2[8] & !c2[0];
    auto = c1[14];
    if ((ms == 0 || ms == 3) && st && auto) ms = 1;
    else if (ms == 2 && !st) ms = 3;
    else if (ms == 4 && rs) ms = 0;
    held = st;
    check_state();
  endtask
  task automatic weld_end();
    @(posedge core_clk_i);
    wdone <= 1'b1;
    @(posedge core_clk_i);
    wdone <= 1'b0;
    ms = 2;
    repeat (2) @(posedge core_clk_i);
    check_state();
  endtask
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (5000) @(posedge core_clk_i);
    errors++;
    end_of_test();
  end
  initial begin
    {arst_n_i, go, tick, wdone, wr, rd, addr, wdata, cw1, cw2, fill} = '0;
    repeat (12) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    check_state();
    bus_wr(fbar_pkg::REG_HOLD_LIMIT, 32'h28);
    bus_rd(fbar_pkg::REG_HOLD_LIMIT, 32'h28);
    bus_wr(fbar_pkg::REG_IRQ_MASK, 32'h1);
    send(16'h0000, 16'h0101);
    send(16'h4000, 16'h0000);
    send(16'h4000, 16'h0101);
    weld_end();
    send(16'h4000, 16'h0000);
    send(16'h4000, 16'h0201);
    weld_end();
    repeat (60) @(posedge core_clk_i);
    ms = 4;
    check_state();
    `CHK(irq, 1'b1)
    send(16'h4000, 16'h0101);
    send(16'h4000, 16'h0000);
    `CHK(sw2[10] & sw2[3], 1'b1)
    @(posedge core_clk_i);
    tick <= 1'b1;
    @(posedge core_clk_i);
    tick <= 1'b0;
    repeat (24) @(posedge core_clk_i);
    #1 `CHK(rx_cnt, 20)
    `CHK(rx[63:32], {esw2(), esw1()})
    `CHK({rx[159:64], rx[31:0]}, 128'h0)
    send(16'h4000, 16'h0100);
    send(16'h4000, 16'h0000);
    bus_rd(fbar_pkg::REG_CONTROL_WORDS, 32'h00004000);
    bus_rd(fbar_pkg::REG_STATUS_WORDS, 32'h04004010);
    bus_rd(8'h14, 32'h0);
    bus_rd(fbar_pkg::REG_IRQ_MASK, 32'h1);
    bus_rd(fbar_pkg::REG_IRQ_STATUS, 32'hF);
    bus_wr(fbar_pkg::REG_IRQ_STATUS, 32'hF);
    repeat (2) @(posedge core_clk_i);
    #1 `CHK(irq, 1'b0)
    bus_rd(fbar_pkg::REG_IRQ_STATUS, 32'h0);
    bus_wr(fbar_pkg::REG_HOLD_LIMIT, 32'h0);
    bus_rd(fbar_pkg::REG_HOLD_LIMIT, 32'h1);
    end_of_test();
  end
endmodule
